// *** logic/rstp_tail_defs.svh ***
// named constants for the host port tail tag and rstp block
// assumes inclusion by bare name from every file of the block
`ifndef RSTP_TAIL_DEFS_SVH
`define RSTP_TAIL_DEFS_SVH

// ****************************************************************
// register map, byte addresses on the axi4-lite slave
// ****************************************************************
`define RT_AXI_AW 8
`define RT_OFF_GLOBAL 8'h00
`define RT_OFF_PORT0 8'h04
`define RT_PORT_STRIDE 4
`define RT_OFF_STATUS 8'h14
`define RT_OFF_TAGINFO 8'h18

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define RT_BIT_TAG_EN 1
`define RT_BIT_FLUSH_DYN 5
`define RT_BIT_FLUSH_STA 4
`define RT_PC_FIELD 2:0
`define RT_PORT_RST 3'h1
`define RT_TAG_INFO 7:0
`define RT_STATE_W 2

// ****************************************************************
// port settings as {transmit, receive, learning inhibit}
// ****************************************************************
`define RT_SET_DISCARD 3'h1
`define RT_SET_LEARN 3'h0
`define RT_SET_FORWARD 3'h6

// ****************************************************************
// tail tag layout
// ****************************************************************
`define RT_NPORT 4
`define RT_TAG_LOOKUP 7
`define RT_TAG_MODE 7:6
`define RT_TAG_QUEUE 5:4
`define RT_TAG_DEST 3:0
`define RT_TAG_OVR 2'h1
`define RT_TAG_QSEL 2'h0
`define RT_DEST_NONE 4'h0
`define RT_TAG_SRC_PAD 6'h00

// ****************************************************************
// frame check sequence and delay windows
// ****************************************************************
`define RT_CRC_POLY 32'hedb88320
`define RT_CRC_INIT 32'hffffffff
`define RT_H_WIN 5
`define RT_D_WIN 4
`define RT_FCS_LAST 2'h3

// ****************************************************************
// axi responses
// ****************************************************************
`define RT_RESP_OKAY 2'h0
`define RT_RESP_SLVERR 2'h2

`endif

// *** logic/rstp_tail_pkg.sv ***
// types shared by the host port tail tag and rstp block
// assumes rstp_tail_defs.svh is on the include path
`include "rstp_tail_defs.svh"

package rstp_tail_pkg;

  typedef enum logic [1:0] {
    ST_DISCARD = 2'b00,
    ST_LEARN = 2'b01,
    ST_FORWARD = 2'b10,
    ST_INVALID = 2'b11
  } rstp_state_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_BODY = 2'b01,
    PH_TAG = 2'b10,
    PH_FCS = 2'b11
  } phase_e;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } byte_strm_s;

  typedef struct packed {
    logic valid;
    logic lookup;
    logic drop;
    logic override;
    logic [1:0] queue;
    logic [3:0] dest;
  } h2d_desc_s;

  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic learn_inh;
  } port_ctrl_s;

  typedef struct packed {
    logic user_fwd;
    logic host_ok;
    logic learn_ok;
  } port_allow_s;

  typedef struct packed {
    logic [`RT_AXI_AW-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [`RT_AXI_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_s;

endpackage : rstp_tail_pkg

// *** logic/crc32_byte_step.sv ***
// one byte step of the reflected ethernet frame check sequence
// assumes the caller holds the running value and applies the final inversion
`timescale 1ns/1ps
`include "rstp_tail_defs.svh"

module crc32_byte_step #(
  parameter logic [31:0] POLY = `RT_CRC_POLY
) (
  input wire logic [31:0] crc_i,
  input wire logic [7:0] byte_i,
  output logic [31:0] crc_o
);
  import rstp_tail_pkg::*;

  logic [31:0] c;

  if (POLY == 32'h0) begin : g_bad_poly
    $error("crc32_byte_step: polynomial must be nonzero");
  end

  always_comb begin
    c = crc_i ^ {24'h0, byte_i};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ POLY) : (c >> 1);
    end
    crc_o = c;
  end

endmodule : crc32_byte_step

// *** logic/rstp_port_decode.sv ***
// decodes one network port's settings into its rstp state and permissions
// assumes settings come from registers on the same clock
`timescale 1ns/1ps
`include "rstp_tail_defs.svh"

module rstp_port_decode (
  input rstp_tail_pkg::port_ctrl_s ctrl_i,
  output rstp_tail_pkg::rstp_state_e state_o,
  output rstp_tail_pkg::port_allow_s allow_o
);
  import rstp_tail_pkg::*;

  always_comb begin
    case ({ctrl_i.tx_en, ctrl_i.rx_en, ctrl_i.learn_inh})
      `RT_SET_DISCARD: state_o = ST_DISCARD;
      `RT_SET_LEARN: state_o = ST_LEARN;
      `RT_SET_FORWARD: state_o = ST_FORWARD;
      default: state_o = ST_INVALID;
    endcase
    allow_o.user_fwd = (state_o == ST_FORWARD);
    allow_o.host_ok = (state_o == ST_LEARN) || (state_o == ST_FORWARD);
    allow_o.learn_ok = !ctrl_i.learn_inh;
  end

endmodule : rstp_port_decode

// *** logic/host_port_tail_tag_rstp.sv ***
// host port tail tag handling and per-port rstp state control
// assumes byte streams on clk_i from the host link mac and the switch fabric
//
// Summary of operation
// - one rstp state kept per network port
// - discarding port: no topology part, no learning
// - learning port learns, passes only host traffic
// - forwarding port forwards, receives and learns
// - tx 0, rx 0, inhibit 1 selects discarding
// - tx 0, rx 0, inhibit 0 selects learning
// - tx 1, rx 1, inhibit 0 selects forwarding
// - flush bits purge inhibited ports' table entries
// - override frames from host reach discarding ports
// - host may direct frames into learning/forwarding ports
// - tail tag only on host port, one byte
// - tag handling only while global enable set
// - tag low nibble selects destination port mask
// - destination taken from low four bits only
// - tag high nibble 00xx selects egress queue
// - high nibble 01xx overrides transmit blocking
// - tag bit 7 set means normal lookup
// - inserted tag low bits name ingress port
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "rstp_tail_defs.svh"

module host_port_tail_tag_rstp #(
  parameter int NPORT = `RT_NPORT
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input rstp_tail_pkg::axi_req_s axi_req_i,
  output rstp_tail_pkg::axi_rsp_s axi_rsp_o,
  input rstp_tail_pkg::byte_strm_s h2d_in_i,
  output rstp_tail_pkg::byte_strm_s h2d_out_o,
  output rstp_tail_pkg::h2d_desc_s h2d_desc_o,
  input rstp_tail_pkg::byte_strm_s d2h_in_i,
  input wire logic [1:0] d2h_src_i,
  output rstp_tail_pkg::byte_strm_s d2h_out_o,
  output logic [NPORT-1:0] learn_en_o,
  output logic [NPORT-1:0] user_fwd_o,
  output logic [NPORT-1:0] host_path_o,
  output logic [NPORT-1:0] flush_dyn_o,
  output logic [NPORT-1:0] flush_sta_o
);
  import rstp_tail_pkg::*;

  localparam int AW = `RT_AXI_AW;
  localparam int HW = `RT_H_WIN;
  localparam int DW = `RT_D_WIN;
  localparam logic [2:0] H_FULL = 3'(`RT_H_WIN);
  localparam logic [2:0] D_FULL = 3'(`RT_D_WIN);

  if (NPORT != `RT_NPORT) begin : g_bad_nport
    $error("host_port_tail_tag_rstp: tag format serves four ports only");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    axi_rsp_s rsp;
    logic aw_held;
    logic w_held;
    logic [AW-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic tag_en;
    port_ctrl_s [NPORT-1:0] pc;
    logic [NPORT-1:0] learn_en;
    logic [NPORT-1:0] user_fwd;
    logic [NPORT-1:0] host_path;
    logic [NPORT-1:0] flush_dyn;
    logic [NPORT-1:0] flush_sta;
    phase_e h_ph;
    logic h_byp;
    logic [2:0] h_cnt;
    logic [HW-1:0][7:0] h_win;
    logic [31:0] h_crc;
    logic [1:0] h_idx;
    logic [7:0] h_tag;
    byte_strm_s h_out;
    h2d_desc_s desc;
    phase_e d_ph;
    logic d_byp;
    logic [2:0] d_cnt;
    logic [DW-1:0][7:0] d_win;
    logic [31:0] d_crc;
    logic [1:0] d_idx;
    logic [1:0] d_src;
    logic d_tag_out;
    byte_strm_s d_out;
  } st_s;

  st_s st_ff;
  st_s nxt_st;

  rstp_state_e pstate [NPORT];
  port_allow_s pallow [NPORT];
  logic [NPORT-1:0] inh_vec;
  logic [NPORT-1:0] disc_vec;
  logic [NPORT-1:0] lrn_vec;
  logic [NPORT-1:0] fwd_vec;
  logic [31:0] h_crc_nx;
  logic [31:0] d_crc_nx;
  logic [7:0] d_tag_byte;
  logic [7:0] d_crc_in;
  logic [31:0] rd_data;
  logic rd_err;
  logic [AW-1:0] wa;
  logic werr;
  logic h_bp;
  logic d_bp;
  logic [2:0] h_c0;
  logic [2:0] d_c0;
  logic [31:0] h_fcs;
  logic [31:0] d_fcs;

  function automatic logic [AW-1:0] port_addr(input int p);
    return `RT_OFF_PORT0 + AW'(p * `RT_PORT_STRIDE);
  endfunction : port_addr

  // destination mask from the tag, blocked ports dropped unless override
  function automatic h2d_desc_s tag_decode(input logic [7:0] tag,
                                           input logic [3:0] host_ok,
                                           input logic byp);
    h2d_desc_s d;
    d = '0;
    d.valid = 1'b1;
    if (byp || tag[`RT_TAG_LOOKUP]) begin
      d.lookup = 1'b1;
    end else begin
      d.override = (tag[`RT_TAG_MODE] == `RT_TAG_OVR);
      if (tag[`RT_TAG_MODE] == `RT_TAG_QSEL) begin
        d.queue = tag[`RT_TAG_QUEUE];
      end
      d.dest = tag[`RT_TAG_DEST] & (host_ok | {4{d.override}});
      d.drop = (d.dest == `RT_DEST_NONE);
    end
    return d;
  endfunction : tag_decode

  // ****************************************************************
  // per-port state decode and helpers
  // ****************************************************************
  for (genvar g = 0; g < NPORT; g++) begin : g_port
    rstp_port_decode u_dec (
      .ctrl_i(st_ff.pc[g]),
      .state_o(pstate[g]),
      .allow_o(pallow[g])
    );
  end

  crc32_byte_step u_h_crc (
    .crc_i(st_ff.h_crc),
    .byte_i(st_ff.h_win[HW-1]),
    .crc_o(h_crc_nx)
  );

  crc32_byte_step u_d_crc (
    .crc_i(st_ff.d_crc),
    .byte_i(d_crc_in),
    .crc_o(d_crc_nx)
  );

  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      inh_vec[p] = st_ff.pc[p].learn_inh;
      disc_vec[p] = (pstate[p] == ST_DISCARD);
      lrn_vec[p] = (pstate[p] == ST_LEARN);
      fwd_vec[p] = (pstate[p] == ST_FORWARD);
    end
    d_tag_byte = {`RT_TAG_SRC_PAD, st_ff.d_src};
    d_crc_in = (st_ff.d_ph == PH_TAG) ? d_tag_byte : st_ff.d_win[DW-1];
    h_fcs = ~st_ff.h_crc;
    d_fcs = ~st_ff.d_crc;
  end

  // ****************************************************************
  // register read decode
  // ****************************************************************
  always_comb begin
    rd_data = '0;
    rd_err = 1'b1;
    wa = {axi_req_i.araddr[AW-1:2], 2'b00};
    if (wa == `RT_OFF_GLOBAL) begin
      rd_err = 1'b0;
      rd_data[`RT_BIT_TAG_EN] = st_ff.tag_en;
    end
    if (wa == `RT_OFF_STATUS) begin
      rd_err = 1'b0;
      for (int p = 0; p < NPORT; p++) begin
        rd_data[`RT_STATE_W*p +: `RT_STATE_W] = pstate[p];
      end
    end
    if (wa == `RT_OFF_TAGINFO) begin
      rd_err = 1'b0;
      rd_data[`RT_TAG_INFO] = st_ff.h_tag;
    end
    for (int p = 0; p < NPORT; p++) begin
      if (wa == port_addr(p)) begin
        rd_err = 1'b0;
        rd_data[`RT_PC_FIELD] = st_ff.pc[p];
      end
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    nxt_st = st_ff;
    werr = 1'b1;
    h_bp = st_ff.h_byp;
    d_bp = st_ff.d_byp;
    h_c0 = st_ff.h_cnt;
    d_c0 = st_ff.d_cnt;

    // axi write: address and data taken in either order
    nxt_st.flush_dyn = '0;
    nxt_st.flush_sta = '0;
    if (st_ff.rsp.bvalid && axi_req_i.bready) begin
      nxt_st.rsp.bvalid = 1'b0;
    end
    if (st_ff.rsp.awready && axi_req_i.awvalid) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.awaddr = axi_req_i.awaddr;
    end
    if (st_ff.rsp.wready && axi_req_i.wvalid) begin
      nxt_st.w_held = 1'b1;
      nxt_st.wdata = axi_req_i.wdata;
      nxt_st.wstrb = axi_req_i.wstrb;
    end
    if (st_ff.aw_held && st_ff.w_held) begin
      if ({st_ff.awaddr[AW-1:2], 2'b00} == `RT_OFF_GLOBAL) begin
        werr = 1'b0;
        if (st_ff.wstrb[0]) begin
          nxt_st.tag_en = st_ff.wdata[`RT_BIT_TAG_EN];
          if (st_ff.wdata[`RT_BIT_FLUSH_DYN]) begin
            nxt_st.flush_dyn = inh_vec;
          end
          if (st_ff.wdata[`RT_BIT_FLUSH_STA]) begin
            nxt_st.flush_sta = inh_vec;
          end
        end
      end
      for (int p = 0; p < NPORT; p++) begin
        if ({st_ff.awaddr[AW-1:2], 2'b00} == port_addr(p)) begin
          werr = 1'b0;
          if (st_ff.wstrb[0]) begin
            nxt_st.pc[p] = st_ff.wdata[`RT_PC_FIELD];
          end
        end
      end
      if ({st_ff.awaddr[AW-1:2], 2'b00} == `RT_OFF_STATUS ||
          {st_ff.awaddr[AW-1:2], 2'b00} == `RT_OFF_TAGINFO) begin
        werr = 1'b0;
      end
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.rsp.bresp = werr ? `RT_RESP_SLVERR : `RT_RESP_OKAY;
    end
    nxt_st.rsp.awready = !nxt_st.aw_held && !nxt_st.rsp.bvalid;
    nxt_st.rsp.wready = !nxt_st.w_held && !nxt_st.rsp.bvalid;

    // axi read: one outstanding, answer one cycle after the address
    if (st_ff.rsp.rvalid && axi_req_i.rready) begin
      nxt_st.rsp.rvalid = 1'b0;
    end
    if (st_ff.rsp.arready && axi_req_i.arvalid) begin
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata = rd_data;
      nxt_st.rsp.rresp = rd_err ? `RT_RESP_SLVERR : `RT_RESP_OKAY;
    end
    nxt_st.rsp.arready = !nxt_st.rsp.rvalid;

    // port permissions toward the fabric
    for (int p = 0; p < NPORT; p++) begin
      nxt_st.learn_en[p] = pallow[p].learn_ok;
      nxt_st.user_fwd[p] = pallow[p].user_fwd;
      nxt_st.host_path[p] = pallow[p].host_ok;
    end

    // host to device: strip tag, recompute fcs
    nxt_st.h_out.valid = 1'b0;
    nxt_st.h_out.last = 1'b0;
    nxt_st.desc.valid = 1'b0;
    case (st_ff.h_ph)
      PH_IDLE, PH_BODY: begin
        if (h2d_in_i.valid) begin
          if (st_ff.h_ph == PH_IDLE) begin
            h_bp = !st_ff.tag_en;
            h_c0 = 3'h0;
            nxt_st.h_crc = `RT_CRC_INIT;
          end
          nxt_st.h_byp = h_bp;
          nxt_st.h_ph = h2d_in_i.last ? PH_IDLE : PH_BODY;
          if (h_bp) begin
            nxt_st.h_out = h2d_in_i;
            if (h2d_in_i.last) begin
              nxt_st.desc = tag_decode(8'h0, st_ff.host_path, 1'b1);
            end
          end else begin
            nxt_st.h_win = {st_ff.h_win[HW-2:0], h2d_in_i.data};
            if (h_c0 == H_FULL) begin
              nxt_st.h_out.data = st_ff.h_win[HW-1];
              nxt_st.h_out.valid = 1'b1;
              nxt_st.h_crc = h_crc_nx;
            end else begin
              nxt_st.h_cnt = h_c0 + 3'h1;
            end
            if (h2d_in_i.last) begin
              nxt_st.h_tag = st_ff.h_win[HW-2];
              nxt_st.h_ph = PH_FCS;
              nxt_st.h_idx = 2'h0;
            end
          end
        end
      end
      PH_FCS: begin
        nxt_st.h_out.valid = 1'b1;
        nxt_st.h_out.data = h_fcs[{st_ff.h_idx, 3'b000} +: 8];
        nxt_st.h_idx = st_ff.h_idx + 2'h1;
        if (st_ff.h_idx == `RT_FCS_LAST) begin
          nxt_st.h_out.last = 1'b1;
          nxt_st.desc = tag_decode(st_ff.h_tag, st_ff.host_path, 1'b0);
          nxt_st.h_ph = PH_IDLE;
        end
      end
      default: nxt_st.h_ph = PH_IDLE;
    endcase

    // device to host: frames the fabric hands over go out, but bytes arriving during tag or fcs output are dropped
    nxt_st.d_out.valid = 1'b0;
    nxt_st.d_out.last = 1'b0;
    nxt_st.d_tag_out = 1'b0;
    case (st_ff.d_ph)
      PH_IDLE, PH_BODY: begin
        if (d2h_in_i.valid) begin
          if (st_ff.d_ph == PH_IDLE) begin
            d_bp = !st_ff.tag_en;
            d_c0 = 3'h0;
            nxt_st.d_crc = `RT_CRC_INIT;
            nxt_st.d_src = d2h_src_i;
          end
          nxt_st.d_byp = d_bp;
          nxt_st.d_ph = d2h_in_i.last ? PH_IDLE : PH_BODY;
          if (d_bp) begin
            nxt_st.d_out = d2h_in_i;
          end else begin
            nxt_st.d_win = {st_ff.d_win[DW-2:0], d2h_in_i.data};
            if (d_c0 == D_FULL) begin
              nxt_st.d_out.data = st_ff.d_win[DW-1];
              nxt_st.d_out.valid = 1'b1;
              nxt_st.d_crc = d_crc_nx;
            end else begin
              nxt_st.d_cnt = d_c0 + 3'h1;
            end
            if (d2h_in_i.last) begin
              nxt_st.d_ph = PH_TAG;
            end
          end
        end
      end
      PH_TAG: begin
        nxt_st.d_out.valid = 1'b1;
        nxt_st.d_out.data = d_tag_byte;
        nxt_st.d_tag_out = 1'b1;
        nxt_st.d_crc = d_crc_nx;
        nxt_st.d_idx = 2'h0;
        nxt_st.d_ph = PH_FCS;
      end
      PH_FCS: begin
        nxt_st.d_out.valid = 1'b1;
        nxt_st.d_out.data = d_fcs[{st_ff.d_idx, 3'b000} +: 8];
        nxt_st.d_idx = st_ff.d_idx + 2'h1;
        if (st_ff.d_idx == `RT_FCS_LAST) begin
          nxt_st.d_out.last = 1'b1;
          nxt_st.d_ph = PH_IDLE;
        end
      end
      default: nxt_st.d_ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      st_ff <= '0;
      st_ff.pc <= {NPORT{`RT_PORT_RST}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign axi_rsp_o = st_ff.rsp;
  assign h2d_out_o = st_ff.h_out;
  assign h2d_desc_o = st_ff.desc;
  assign d2h_out_o = st_ff.d_out;
  assign learn_en_o = st_ff.learn_en;
  assign user_fwd_o = st_ff.user_fwd;
  assign host_path_o = st_ff.host_path;
  assign flush_dyn_o = st_ff.flush_dyn;
  assign flush_sta_o = st_ff.flush_sta;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_disc_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ((learn_en_o | user_fwd_o | host_path_o) & $past(disc_vec)) == '0)
    else $error("discarding port still learns or passes traffic");

  a_learn_host_only: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ((user_fwd_o & $past(lrn_vec)) == '0) &&
    ((host_path_o & learn_en_o & $past(lrn_vec)) == $past(lrn_vec)))
    else $error("learning port permissions wrong");

  a_fwd_full: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ($past(fwd_vec) & ~(user_fwd_o & host_path_o & learn_en_o)) == '0)
    else $error("forwarding port not fully enabled");

  a_flush_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (flush_dyn_o != '0 || flush_sta_o != '0) |->
    (((flush_dyn_o | flush_sta_o) & ~$past(inh_vec)) == '0)
    ##1 (flush_dyn_o == '0 && flush_sta_o == '0))
    else $error("flush hit a learning port or lasted too long");

  a_tag_lookup: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (h2d_desc_o.valid && !st_ff.h_byp && st_ff.h_tag[`RT_TAG_LOOKUP]) |->
    (h2d_desc_o.lookup && h2d_desc_o.dest == `RT_DEST_NONE))
    else $error("tag bit 7 did not force lookup");

  a_tag_queue: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (h2d_desc_o.valid && !st_ff.h_byp &&
     st_ff.h_tag[`RT_TAG_MODE] == `RT_TAG_QSEL) |->
    (h2d_desc_o.queue == st_ff.h_tag[`RT_TAG_QUEUE] && !h2d_desc_o.lookup))
    else $error("queue select wrong");

  a_ovr_dest: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (h2d_desc_o.valid && !st_ff.h_byp &&
     st_ff.h_tag[`RT_TAG_MODE] == `RT_TAG_OVR) |->
    (h2d_desc_o.override && h2d_desc_o.dest == st_ff.h_tag[`RT_TAG_DEST]))
    else $error("blocking override lost ports");

  a_dest_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (h2d_desc_o.valid && !h2d_desc_o.lookup && !h2d_desc_o.override) |->
    (h2d_desc_o.dest == (st_ff.h_tag[`RT_TAG_DEST] & $past(st_ff.host_path))))
    else $error("destination mask wrong");

  a_bypass_lookup: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (h2d_desc_o.valid && st_ff.h_byp) |-> h2d_desc_o.lookup)
    else $error("untagged frame not sent to lookup");

  a_fcs_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_ff.h_ph == PH_FCS && st_ff.h_idx == 2'h0) |=>
    h2d_out_o.valid [*4] ##0 (h2d_out_o.last && h2d_desc_o.valid))
    else $error("stripped frame fcs length wrong");

  a_d2h_insert: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (st_ff.d_ph == PH_TAG) |=> st_ff.d_tag_out ##1
    d2h_out_o.valid [*4] ##0 d2h_out_o.last)
    else $error("tag and fcs not appended");

  a_d2h_tag_byte: assert property (@(posedge clk_i) disable iff (!nrst_i)
    st_ff.d_tag_out |->
    (d2h_out_o.valid && d2h_out_o.data == {`RT_TAG_SRC_PAD, st_ff.d_src}))
    else $error("inserted tag byte wrong");

endmodule : host_port_tail_tag_rstp

// *** sim/host_link_model.sv ***
// host processor side of the host port: sends one tagged frame per go pulse
// assumes go_i and tag_i change right after a rising edge
`timescale 1ns/1ps
`include "rstp_tail_defs.svh"

module host_link_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [7:0] tag_i,
  output rstp_tail_pkg::byte_strm_s strm_o
);
  import rstp_tail_pkg::*;
  logic [3:0] n_ff = 4'hf;
  // ****************************************************************
  // six data bytes, tag, four check bytes
  // ****************************************************************
  always @(posedge clk_i) begin
    if (go_i && n_ff == 4'hf) n_ff <= 4'h0;
    else if (n_ff != 4'hf) n_ff <= (n_ff == 4'ha) ? 4'hf : n_ff + 4'h1;
  end
  assign strm_o.valid = n_ff != 4'hf;
  assign strm_o.last = n_ff == 4'ha;
  // tag from the bench; three rows probe a discarding port on purpose
  // tag just before the check bytes; idle line inverts last byte
  assign strm_o.data = n_ff < 4'h6 ? 8'h10 + {4'h0, n_ff} :
                       n_ff == 4'h6 ? tag_i :
                       n_ff == 4'hf ? 8'h35 : 8'hc0 + {4'h0, n_ff};
endmodule : host_link_model

// *** sim/host_port_tail_tag_rstp_tb_top.sv ***
// bench for the host port tail tag and rstp block
// assumes host_link_model drives both frame streams
`timescale 1ns/1ps
`include "rstp_tail_defs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  fail_count++; $display("[ERR] %0t %h %h", $time, a, b); end end

module host_port_tail_tag_rstp_tb_top;
  import rstp_tail_pkg::*;
  logic clk_i = 0, nrst_i = 0, go = 0, go2 = 0;
  logic [7:0] tag = 0;
  logic [1:0] src = 0;
  axi_req_s rq = '0;
  axi_rsp_s rs;
  byte_strm_s hi, ho, di, dout;
  h2d_desc_s dsc, dq = '0;
  logic [3:0] le, uf, hp, fd, fs, fld = 0, fls = 0;
  logic [31:0] hist = 0, d;
  logic [31:0] hh = 0, hfcs = 0, dfcs = 0, ef, ed;
  logic [7:0] dtag = 0, hdat = 0;
  logic [1:0] r;
  int fail_count = 0, checks_done = 0;
  logic [17:0] rows [8] = '{{8'h01, 10'h280}, {8'h12, 10'h212},
    {8'h24, 10'h224}, {8'h38, 10'h238}, {8'h0f, 10'h20e},
    {8'h41, 10'h241}, {8'h9f, 10'h300}, {8'h00, 10'h280}};
  always #4 clk_i = ~clk_i;
  host_port_tail_tag_rstp dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .axi_req_i(rq), .axi_rsp_o(rs), .h2d_in_i(hi), .h2d_out_o(ho),
    .h2d_desc_o(dsc), .d2h_in_i(di), .d2h_src_i(src), .d2h_out_o(dout),
    .learn_en_o(le), .user_fwd_o(uf), .host_path_o(hp),
    .flush_dyn_o(fd), .flush_sta_o(fs));
  host_link_model h_u (.clk_i(clk_i), .go_i(go), .tag_i(tag), .strm_o(hi));
  host_link_model f_u (.clk_i(clk_i), .go_i(go2), .tag_i(8'h77),
    .strm_o(di));
  // ****************************************************************
  // capture of pulses and inserted tag
  // ****************************************************************
  always @(posedge clk_i) begin
    if (dsc.valid) dq <= dsc;
    if (fd != 0) fld <= fd;
    if (fs != 0) fls <= fs;
    if (dout.valid) hist <= {hist[23:0], dout.data};
    if (dout.valid && dout.last) dtag <= hist[31:24];
    if (dout.valid && dout.last) begin
      dfcs <= {dout.data, hist[7:0], hist[15:8], hist[23:16]};
    end
    if (ho.valid) hh <= {hh[23:0], ho.data};
    if (ho.valid && ho.last) begin
      hdat <= hh[31:24];
      hfcs <= {ho.data, hh[7:0], hh[15:8], hh[23:16]};
    end
  end
  // reference frame check sequence, one byte step
  function automatic logic [31:0] crc_upd(input logic [31:0] c,
                                          input logic [7:0] b);
    c = c ^ {24'h0, b};
    for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ `RT_CRC_POLY : c >> 1;
    return c;
  endfunction : crc_upd
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    rq.awaddr <= a; rq.wdata <= v; rq.wstrb <= 4'hf;
    rq.awvalid <= 1; rq.wvalid <= 1; rq.bready <= 1;
    do begin
      @(posedge clk_i);
      if (rs.awready) rq.awvalid <= 0;
      if (rs.wready) rq.wvalid <= 0;
    end while (!rs.bvalid);
    rq.bready <= 0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_i);
    rq.araddr <= a; rq.arvalid <= 1; rq.rready <= 1;
    do begin
      @(posedge clk_i);
      if (rs.arready) rq.arvalid <= 0;
    end while (!rs.rvalid);
    d = rs.rdata; r = rs.rresp; rq.rready <= 0;
  endtask : rd
  task frame(input logic [7:0] t);
    @(posedge clk_i) begin tag <= t; go <= 1; end
    @(posedge clk_i) go <= 0;
    repeat (30) @(posedge clk_i);
  endtask : frame
  task dframe(input logic [1:0] s);
    @(posedge clk_i) begin src <= s; go2 <= 1; end
    @(posedge clk_i) go2 <= 0;
    repeat (30) @(posedge clk_i);
  endtask : dframe
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    print_verdict;
  end
  initial begin
    ef = `RT_CRC_INIT;
    for (int i = 0; i < 6; i++) ef = crc_upd(ef, 8'h10 + 8'(i));
    ed = crc_upd(crc_upd(ef, 8'h77), 8'h02);
    repeat (5) @(posedge clk_i);
    nrst_i <= 1;
    rd(8'h04); `CHK(d, 32'h1)
    rd(8'h1c); `CHK(r, 2'h2)
    wr(8'h04, 1); wr(8'h08, 0); wr(8'h0c, 6); wr(8'h10, 6);
    wr(8'h00, 32'h32);
    @(posedge clk_i);
    `CHK({fld, fls}, 8'h11)
    rd(8'h14); `CHK(d, 32'ha4)
    `CHK({le, uf, hp}, 12'hece)
    for (int i = 0; i < 8; i++) begin
      frame(rows[i][17:10]);
      `CHK(dq, rows[i][9:0])
      `CHK(hdat, 8'h15)
      `CHK(hfcs, ~ef)
      rd(8'h18); `CHK(d, 32'(rows[i][17:10]))
    end
    dframe(2'h2);
    `CHK(dtag, 8'h02)
    `CHK(dfcs, ~ed)
    dframe(2'h0); `CHK(dtag, 8'h00)
    wr(8'h00, 0);
    frame(8'h01); `CHK(dq, 10'h300)
    `CHK(hdat, 8'h01)
    `CHK(hfcs, 32'hcac9c8c7)
    print_verdict;
  end
endmodule : host_port_tail_tag_rstp_tb_top
